//--- design/adcsq_pkg.sv
// Behaviour
// [RQ1] Writing one to bit 31 restarts the sequence at the first selected input; self-clears.
// [RQ2] Writing one to bit 30 enables the sequencer; write-only, resets to zero.
// [RQ3] Hold flag reads one only while the converter is being stalled.
// [RQ4] Software sets the hold flag during its stall procedure; it is writable.
// [RQ5] A 29-bit pick mask selects inputs; one includes, zero skips.
// [RQ6] Mask bit position equals the input's single-input select code.
// [RQ7] With chopped buffer, software enables an odd number of inputs.
// [RQ8] With chopped buffer, software runs two sequences and averages results.
// [RQ9] Delay 0..254 spaces repeated sequences; 255 halts after one sequence.
// [RQ10] Busy reads one while converting or waiting in delay, zero when done.
// [RQ11] Selected inputs are visited once each in ascending bit order.
package adcsq_pkg;
  localparam logic [31:0] ADCSQ_CTRL_ADDR = 32'h40086088;
  localparam logic [31:0] ADCSQ_STAT_ADDR = 32'h40086084;
  localparam logic [31:0] ADCSQ_CFG_ADDR = 32'h4008608C;
  localparam logic [11:0] ADCSQ_ADDR_MASK = 12'hFFF;
  localparam int ADCSQ_RESTART_BIT = 31;
  localparam int ADCSQ_RUN_BIT = 30;
  localparam int ADCSQ_HOLD_BIT = 29;
  localparam int ADCSQ_MASK_W = 29;
  localparam int ADCSQ_SEL_W = 5;
  localparam int ADCSQ_BUSY_BIT = 2;
  localparam int ADCSQ_HOLDST_BIT = 1;
  localparam int ADCSQ_DLY_LSB = 20;
  localparam int ADCSQ_DLY_W = 8;
  localparam logic [7:0] ADCSQ_DLY_RST = 8'hFF;
  localparam logic [7:0] ADCSQ_DLY_HALT = 8'hFF;
  localparam logic [31:0] ADCSQ_CTRL_RST = 32'h00000000;
  localparam logic [1:0] ADCSQ_HTRANS_NONSEQ = 2'h2;
  typedef enum logic [1:0] {
    ADCSQ_IDLE = 2'b00,
    ADCSQ_CONV = 2'b01,
    ADCSQ_WAIT = 2'b11
  } adcsq_state_t;
endpackage

//--- design/adcsq_picker.sv
`timescale 1ns/1ps
`default_nettype none
// Finds the lowest selected input at or above a start position
module adcsq_picker
  import adcsq_pkg::*;
#(
  parameter int MASK_W = ADCSQ_MASK_W
) (
  // Search
  input wire logic [MASK_W-1:0] pick_mask,
  input wire logic [ADCSQ_SEL_W-1:0] start_pos,
  // Result
  output logic found,
  output logic [ADCSQ_SEL_W-1:0] found_pos
);
  always_comb begin
    found = 1'b0;
    found_pos = '0;
    for (int i = MASK_W - 1; i >= 0; i--) begin
      if (pick_mask[i] && (i >= int'(start_pos))) begin // [RQ11]
        found = 1'b1;
        found_pos = ADCSQ_SEL_W'(i); // [RQ6]
      end
    end
  end
endmodule
`default_nettype wire

//--- design/adcsq_top.sv
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module adcsq_top
  import adcsq_pkg::*;
#(
  parameter int MASK_W = ADCSQ_MASK_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Converter side
  input wire logic conv_done,
  output logic conv_start,
  output logic [ADCSQ_SEL_W-1:0] single_input_select,
  output logic sequencer_busy_flag,
  output logic sequencer_hold_flag
);
  logic [MASK_W-1:0] mask_reg, mask_next;
  logic hold_reg, hold_next;
  logic [ADCSQ_DLY_W-1:0] dly_reg, dly_next;
  logic [ADCSQ_DLY_W-1:0] wait_reg, wait_next;
  adcsq_state_t state_reg, state_next;
  logic [ADCSQ_SEL_W-1:0] sel_reg, sel_next;
  logic start_reg, start_next;
  logic busy_reg, busy_next;
  logic [31:0] rdata_reg, rdata_next;
  logic wr_pend_reg, wr_pend_next;
  logic [11:0] wa_reg, wa_next;
  logic pick_found;
  logic [ADCSQ_SEL_W-1:0] pick_pos, pick_from;
  logic wr_ctrl, restart, run;

  function automatic logic addr_is(input logic [11:0] a, input logic [31:0] reg_addr);
    return a == (reg_addr[11:0] & ADCSQ_ADDR_MASK);
  endfunction

  wire logic take = hsel && hready && (htrans == ADCSQ_HTRANS_NONSEQ);

  // The search sees a mask written together with run or restart
  adcsq_picker #(.MASK_W(MASK_W)) u_picker (
    .pick_mask(mask_next),
    .start_pos(pick_from),
    .found(pick_found),
    .found_pos(pick_pos)
  );

  assign wr_ctrl = wr_pend_reg && addr_is(wa_reg, ADCSQ_CTRL_ADDR);
  assign restart = wr_ctrl && hwdata[ADCSQ_RESTART_BIT]; // [RQ1]
  assign run = wr_ctrl && hwdata[ADCSQ_RUN_BIT]; // [RQ2]

  // Register file and bus; writes land in the data phase, zero wait states
  always_comb begin
    mask_next = mask_reg;
    hold_next = hold_reg;
    dly_next = dly_reg;
    wa_next = haddr[11:0];
    wr_pend_next = take && hwrite;
    rdata_next = 32'h00000000;
    if (wr_ctrl) begin
      mask_next = hwdata[MASK_W-1:0]; // [RQ5]
      hold_next = hwdata[ADCSQ_HOLD_BIT]; // [RQ3] [RQ4]
    end
    if (wr_pend_reg && addr_is(wa_reg, ADCSQ_CFG_ADDR)) begin
      dly_next = hwdata[ADCSQ_DLY_LSB +: ADCSQ_DLY_W];
    end
    if (take && !hwrite) begin
      if (addr_is(haddr[11:0], ADCSQ_CTRL_ADDR)) begin
        rdata_next[MASK_W-1:0] = mask_reg;
        rdata_next[ADCSQ_HOLD_BIT] = hold_reg; // Run and restart read zero
      end else if (addr_is(haddr[11:0], ADCSQ_STAT_ADDR)) begin
        rdata_next[ADCSQ_BUSY_BIT] = busy_reg; // [RQ10]
        rdata_next[ADCSQ_HOLDST_BIT] = hold_reg;
      end else if (addr_is(haddr[11:0], ADCSQ_CFG_ADDR)) begin
        rdata_next[ADCSQ_DLY_LSB +: ADCSQ_DLY_W] = dly_reg;
      end
    end
  end

  // Search from the bottom except while walking a pass
  always_comb begin
    pick_from = '0;
    if (state_reg == ADCSQ_CONV && !restart) begin
      pick_from = sel_reg + ADCSQ_SEL_W'(1);
    end
  end

  // Sequencer
  always_comb begin
    state_next = state_reg;
    sel_next = sel_reg;
    wait_next = wait_reg;
    start_next = 1'b0;
    case (state_reg)
      ADCSQ_IDLE: begin
        if (run && pick_found) begin // [RQ2]
          state_next = ADCSQ_CONV;
          sel_next = pick_pos;
          start_next = 1'b1;
        end
      end
      ADCSQ_CONV: begin
        if (restart) begin // [RQ1]
          sel_next = pick_pos;
          start_next = pick_found;
          state_next = pick_found ? ADCSQ_CONV : ADCSQ_IDLE;
        end else if (hold_reg) begin
          state_next = ADCSQ_CONV;
        end else if (conv_done) begin
          if (pick_found && sel_reg != ADCSQ_SEL_W'(MASK_W - 1)) begin // [RQ11]
            sel_next = pick_pos;
            start_next = 1'b1;
          end else if (dly_reg == ADCSQ_DLY_HALT) begin // [RQ9]
            state_next = ADCSQ_IDLE;
          end else begin
            state_next = ADCSQ_WAIT;
            wait_next = dly_reg;
          end
        end
      end
      ADCSQ_WAIT: begin
        if (restart || (wait_reg == '0 && !hold_reg)) begin // [RQ9]
          if (pick_found) begin
            state_next = ADCSQ_CONV;
            sel_next = pick_pos;
            start_next = 1'b1;
          end else begin
            state_next = ADCSQ_IDLE;
          end
        end else if (wait_reg != '0) begin
          wait_next = wait_reg - ADCSQ_DLY_W'(1);
        end
      end
      default: state_next = ADCSQ_IDLE;
    endcase
    busy_next = (state_next != ADCSQ_IDLE); // [RQ10]
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mask_reg <= '0;
      hold_reg <= 1'b0;
      dly_reg <= ADCSQ_DLY_RST;
      wait_reg <= '0;
      state_reg <= ADCSQ_IDLE;
      sel_reg <= '0;
      start_reg <= 1'b0;
      busy_reg <= 1'b0;
      rdata_reg <= ADCSQ_CTRL_RST;
      wr_pend_reg <= 1'b0;
      wa_reg <= '0;
    end else begin
      mask_reg <= mask_next;
      hold_reg <= hold_next;
      dly_reg <= dly_next;
      wait_reg <= wait_next;
      state_reg <= state_next;
      sel_reg <= sel_next;
      start_reg <= start_next;
      busy_reg <= busy_next;
      rdata_reg <= rdata_next;
      wr_pend_reg <= wr_pend_next;
      wa_reg <= wa_next;
    end
  end

  assign hrdata = rdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign conv_start = start_reg;
  assign single_input_select = sel_reg;
  assign sequencer_busy_flag = busy_reg;
  assign sequencer_hold_flag = hold_reg;

  a_run_starts: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ2]
    (state_reg == ADCSQ_IDLE && run && pick_found) |=> (conv_start && sequencer_busy_flag))
    else $error("run did not start the sequencer");
  a_restart_first: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ1]
    (state_reg == ADCSQ_CONV && restart && mask_next[0]) |=> (single_input_select == '0 && conv_start))
    else $error("restart did not return to first input");
  a_sel_in_mask: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ6]
    conv_start |-> mask_reg[single_input_select])
    else $error("converted input not selected");
  a_hold_follows: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ3]
    wr_ctrl |=> sequencer_hold_flag == $past(hwdata[ADCSQ_HOLD_BIT]))
    else $error("hold flag not written");
  a_hold_freezes: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ3]
    (state_reg == ADCSQ_CONV && hold_reg && !restart) |=> (!conv_start && $stable(single_input_select)))
    else $error("hold did not freeze the walk");
  a_halt_single: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ9]
    (state_reg == ADCSQ_CONV && conv_done && !restart && !hold_reg && !start_next
     && dly_reg == ADCSQ_DLY_HALT) |=> ##1 !sequencer_busy_flag)
    else $error("halt setting did not stop");
  a_wait_spacing: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ9]
    (state_reg == ADCSQ_WAIT && wait_reg != '0 && !restart) |=> (state_reg == ADCSQ_WAIT && !conv_start))
    else $error("delay cut short");
  a_busy_state: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ10]
    sequencer_busy_flag == (state_reg != ADCSQ_IDLE))
    else $error("busy flag disagrees with state");
  a_ascending: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ11]
    (state_reg == ADCSQ_CONV && conv_done && !restart && !hold_reg && start_next)
    |=> single_input_select > $past(single_input_select))
    else $error("inputs not ascending");
  a_mask_write: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ5]
    wr_ctrl |=> mask_reg == $past(hwdata[MASK_W-1:0]))
    else $error("mask not written");
  a_ctrl_wo: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ1] [RQ2]
    hrdata[ADCSQ_RESTART_BIT] == 1'b0 && hrdata[ADCSQ_RUN_BIT] == 1'b0)
    else $error("write-only bits read back");
  c_single: cover property (@(posedge mclk) disable iff (!rst_n)
    sequencer_busy_flag ##[1:200] !sequencer_busy_flag);
  c_restart: cover property (@(posedge mclk) disable iff (!rst_n) state_reg == ADCSQ_CONV && restart);
  c_wait: cover property (@(posedge mclk) disable iff (!rst_n) state_reg == ADCSQ_WAIT ##1 conv_start);
  c_hold: cover property (@(posedge mclk) disable iff (!rst_n) state_reg == ADCSQ_CONV && hold_reg && conv_done);
endmodule
`default_nettype wire

//--- sim/adcsq_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module adcsq_tb_top;
  import adcsq_pkg::*;
  logic mclk, rst_n, hsel, hwrite, conv_done, done_en, rd_dp;
  logic hreadyout, hresp, conv_start, busy, hold;
  logic [31:0] haddr, hwdata, hrdata, rng;
  logic [28:0] m;
  logic [1:0] htrans;
  logic [2:0] hsize, dly;
  logic [4:0] sel;
  int fails, cmp_count;
  logic [31:0] rq[$];
  logic [4:0] sq[$];
  adcsq_top u_dut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .conv_done(conv_done), .conv_start(conv_start), .single_input_select(sel), .sequencer_busy_flag(busy),
    .sequencer_hold_flag(hold));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_sel(input logic [4:0] got);
    if (sq.size() == 0) chk({27'h0, got}, 32'hFFFFFFFF, "unexpected start");
    else chk({27'h0, got}, {27'h0, sq.pop_front()}, "select");
  endtask
  // Master never assumes a latency: each phase waits for hready, bounded
  task automatic bus(input logic [31:0] a, input logic [31:0] d, input logic w);
    int n;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= ADCSQ_HTRANS_NONSEQ;
    n = 0;
    do begin @(posedge mclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    rd_dp <= !w;
    do begin @(posedge mclk); n++; end while (hreadyout !== 1'b1 && n < 100);
    rd_dp <= 1'b0;
    chk({31'h0, n < 100}, 32'h1, "bus wait");
    if (n >= 100) give_verdict();
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(a, 32'h0, 1'b0);
  endtask
  task automatic wait_q();
    int n;
    n = 0;
    while (sq.size() != 0 && n < 500) begin @(posedge mclk); n++; end
    chk({31'h0, n < 500}, 32'h1, "start wait");
    if (n >= 500) give_verdict();
  endtask
  task automatic wait_idle();
    int n;
    repeat (2) @(posedge mclk);
    chk({31'h0, busy}, 32'h1, "busy");
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin @(posedge mclk); n++; end
    chk({31'h0, busy}, 32'h0, "idle");
    if (busy !== 1'b0) give_verdict();
    chk(sq.size(), 32'h0, "starts left");
  endtask
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Converter answers four cycles after each start, only while enabled
  always @(posedge mclk) begin
    // A disabled converter drops work in flight, so no stale done follows
    if (!rst_n || !done_en) begin
      dly <= 3'h0;
      conv_done <= 1'b0;
    end else begin
      dly <= {dly[1:0], conv_start === 1'b1};
      conv_done <= dly[2];
    end
    if (rd_dp && hreadyout) begin
      chk({31'h0, hresp}, 32'h0, "resp");
      if (rq.size() == 0) chk(hrdata, 32'hFFFFFFFF, "unexpected read");
      else chk(hrdata, rq.pop_front(), "read");
    end
    if (conv_start === 1'b1) chk_sel(sel);
  end
  initial begin
    #700000;
    fails++;
    give_verdict();
  end
  initial begin
    rng = 32'h6f696d2e;
    {rst_n, hsel, hwrite, rd_dp} = '0;
    {haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    done_en = 1'b1;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    rd(ADCSQ_CTRL_ADDR, ADCSQ_CTRL_RST);
    rd(ADCSQ_STAT_ADDR, 32'h0);
    rd(32'h40086100, 32'h0);
    rd(ADCSQ_CFG_ADDR, {4'h0, ADCSQ_DLY_RST, 20'h00000});
    sq = '{5'h00, 5'h01, 5'h04, 5'h05};
    bus(ADCSQ_CTRL_ADDR, 32'h40000033, 1'b1);
    wait_idle();
    rd(ADCSQ_CTRL_ADDR, 32'h00000033);
    // Restart while the first input is still converting
    done_en <= 1'b0;
    sq = '{5'h00};
    bus(ADCSQ_CTRL_ADDR, 32'h40000033, 1'b1);
    wait_q();
    sq = '{5'h00, 5'h01, 5'h04, 5'h05};
    bus(ADCSQ_CTRL_ADDR, 32'h80000033, 1'b1);
    done_en <= 1'b1;
    wait_idle();
    // Hold freezes the walk; the done pulse is lost, so a restart begins it again at input 0
    sq = '{5'h00};
    bus(ADCSQ_CTRL_ADDR, 32'h60000003, 1'b1);
    repeat (20) @(posedge mclk);
    chk({31'h0, hold}, 32'h1, "hold");
    chk(sq.size(), 32'h0, "held");
    rd(ADCSQ_CTRL_ADDR, 32'h20000003);
    rd(ADCSQ_STAT_ADDR, 32'h00000006);
    sq = '{5'h00, 5'h01};
    bus(ADCSQ_CTRL_ADDR, 32'h80000003, 1'b1);
    wait_idle();
    chk({31'h0, hold}, 32'h0, "released");
    // A short delay repeats the sequence until the halt value is restored
    bus(ADCSQ_CFG_ADDR, 32'h00200000, 1'b1);
    rd(ADCSQ_CFG_ADDR, 32'h00200000);
    sq = '{5'h00, 5'h00, 5'h00};
    bus(ADCSQ_CTRL_ADDR, 32'h40000001, 1'b1);
    wait_q();
    done_en <= 1'b0;
    bus(ADCSQ_CFG_ADDR, 32'h0FF00000, 1'b1);
    sq = '{5'h00};
    done_en <= 1'b1;
    bus(ADCSQ_CTRL_ADDR, 32'h80000001, 1'b1);
    wait_idle();
    for (int k = 0; k < 3; k++) begin
      rng = xs(rng);
      m = rng[28:0];
      m[0] = m[0] ^ ~(^m);
      for (int r = 0; r < 2; r++) begin
        for (int b = 0; b < ADCSQ_MASK_W; b++) if (m[b]) sq.push_back(b[4:0]);
        bus(ADCSQ_CTRL_ADDR, {3'b010, m}, 1'b1);
        wait_idle();
      end
    end
    give_verdict();
  end
endmodule
`default_nettype wire
